//--- shared/cocr_pkg.sv
// Purpose: constants and carriers of the charger option register bank
// Assumes: 125 MHz system clock
// Notes  : all registers are 16 bits wide
package cocr_pkg;
   // ************************************************************
   // command codes and reset values
   // ************************************************************
   localparam logic [7:0]  CMD_PROT  = 8'h3D;
   localparam logic [7:0]  CMD_OPT   = 8'h4C;
   localparam logic [7:0]  CMD_THR   = 8'h4E;
   localparam logic [15:0] PROT_RST  = 16'h0000;
   localparam logic [15:0] OPT_RST   = 16'h0000;
   localparam logic [15:0] THR_RST   = 16'h0000;
   localparam logic [15:0] OPT_WMASK = 16'hFFFB;
   localparam logic [15:0] THR_WMASK = 16'h00FD;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int PROT_REV_DB   = 13;
   localparam int PROT_CMP_REF  = 4;
   localparam int PROT_CMP_DIS  = 3;
   localparam int PROT_CMP_INV  = 2;
   localparam int PROT_SOC_DIS  = 1;
   localparam int PROT_BOV_EN   = 0;
   localparam int OPT_NO_REREAD = 15;
   localparam int OPT_NO_RELOAD = 14;
   localparam int OPT_TERM_LONG = 13;
   localparam int OPT_TMO_HI    = 12;
   localparam int OPT_TMO_LO    = 11;
   localparam int OPT_SHIP      = 10;
   localparam int OPT_PWR_GAIN  = 9;
   localparam int OPT_IDM_LONG  = 8;
   localparam int OPT_HOST_CHG  = 7;
   localparam int OPT_FB_HALF   = 6;
   localparam int OPT_ICL_DIS   = 5;
   localparam int OPT_ICL_BDIS  = 4;
   localparam int OPT_MON_REV   = 3;
   localparam int OPT_SOFT_RST  = 2;
   localparam int OPT_PERIOD_X2 = 1;
   localparam int OPT_REV_FAST  = 0;
   localparam int THR_EN_REVOC  = 7;
   localparam int THR_EN_BATABS = 6;
   localparam int THR_EN_ADP    = 5;
   localparam int THR_EN_CMP    = 4;
   localparam int THR_DB_HI     = 3;
   localparam int THR_DB_LO     = 2;
   localparam int THR_CLR       = 1;
   localparam int THR_LATCH     = 0;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int DB_W        = 15;
   localparam int TMO_W       = 35;
   localparam int CLK_MHZ     = 125;
   localparam longint CLK_KHZ = 125000;
   localparam int DB0_NS      = 2000;
   localparam int DB1_NS      = 25000;
   localparam int DB2_NS      = 125000;
   localparam int DB3_NS      = 250000;
   localparam logic [DB_W-1:0] DB0_CYC = DB_W'((DB0_NS * CLK_MHZ + 999) / 1000);
   localparam logic [DB_W-1:0] DB1_CYC = DB_W'((DB1_NS * CLK_MHZ + 999) / 1000);
   localparam logic [DB_W-1:0] DB2_CYC = DB_W'((DB2_NS * CLK_MHZ + 999) / 1000);
   localparam logic [DB_W-1:0] DB3_CYC = DB_W'((DB3_NS * CLK_MHZ + 999) / 1000);
   localparam longint TMO0_MS = 175000;
   localparam longint TMO1_MS = 87500;
   localparam longint TMO2_MS = 43750;
   localparam longint TMO3_MS = 5000;
   localparam logic [TMO_W-1:0] TMO0_CYC = TMO_W'(TMO0_MS * CLK_KHZ);
   localparam logic [TMO_W-1:0] TMO1_CYC = TMO_W'(TMO1_MS * CLK_KHZ);
   localparam logic [TMO_W-1:0] TMO2_CYC = TMO_W'(TMO2_MS * CLK_KHZ);
   localparam logic [TMO_W-1:0] TMO3_CYC = TMO_W'(TMO3_MS * CLK_KHZ);
   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0]  cmd;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } cocr_req_t;
   typedef struct packed {
      logic       cmp_ref_2v;
      logic       cmp_enable;
      logic       sev_oc_prot_en;
      logic       bat_ov_prot_en;
      logic       rev_db_short;
      logic       reread_disable;
      logic       reload_disable;
      logic       term_200ms;
      logic [1:0] timeout_sel;
      logic       batt_gate_force_off;
      logic       power_gain_low;
      logic       idm_exit_80ms;
      logic       host_charge_ctrl;
      logic       fb_gain_half;
      logic       icl_loop_en;
      logic       monitor_reverse;
      logic       period_double;
      logic       rev_start_1ms;
   } cocr_cfg_t;
endpackage

//--- rtl/cocr_debounce.sv
// Purpose: level qualifier, output rises after the level held a set number of cycles
// Assumes: level_i synchronous to sys_clk_i
// Notes  : output drops in the cycle after the level drops
`timescale 1ns/1ps
`default_nettype none
module cocr_debounce #(
   parameter int W = 15
) (
   input  wire logic         sys_clk_i,
   input  wire logic         srst_i,
   input  wire logic         level_i,
   input  wire logic [W-1:0] cycles_i,
   output var  logic         stable_o
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         stable_r;
   logic         stable_nxt;

   always_comb begin
      cnt_nxt    = cnt_r;
      stable_nxt = stable_r;
      if (!level_i) begin
         cnt_nxt    = '0;
         stable_nxt = 1'b0;
      end else if (!stable_r) begin
         if (cnt_r + W'(1) >= cycles_i) begin
            stable_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cnt_r    <= '0;
         stable_r <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         stable_r <= stable_nxt;
      end
   end

   assign stable_o = stable_r;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   a_drop_follows_level: assert property (!level_i |=> !stable_o)
      else $error("qualified level did not drop");
   a_rise_needs_level: assert property ($rose(stable_o) |-> $past(level_i))
      else $error("qualified level rose without input");
endmodule // cocr_debounce
`default_nettype wire

//--- rtl/cocr_alert.sv
// Purpose: throttle alert output with optional latch and clear
// Assumes: clear_i is a one-cycle pulse
// Notes  : a trip in the clear cycle keeps the alert set
`timescale 1ns/1ps
`default_nettype none
module cocr_alert (
   input  wire logic sys_clk_i,
   input  wire logic srst_i,
   input  wire logic trip_i,
   input  wire logic latch_i,
   input  wire logic clear_i,
   output var  logic alert_n_o
);
   logic held_r;
   logic held_nxt;
   logic alert_n_r;
   logic alert_n_nxt;

   always_comb begin
      held_nxt    = latch_i & (trip_i | (held_r & ~clear_i));
      alert_n_nxt = ~(trip_i | held_nxt);
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         held_r    <= 1'b0;
         alert_n_r <= 1'b1;
      end else begin
         held_r    <= held_nxt;
         alert_n_r <= alert_n_nxt;
      end
   end

   assign alert_n_o = alert_n_r;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   a_trip_asserts: assert property (trip_i |=> !alert_n_o)
      else $error("trip did not assert alert");
   a_auto_clear: assert property (!latch_i && !trip_i |=> alert_n_o)
      else $error("alert not auto cleared");
   a_latch_holds: assert property (held_r && latch_i && !clear_i |=> !alert_n_o)
      else $error("latched alert released without clear");
endmodule // cocr_alert
`default_nettype wire

//--- rtl/cocr_regs.sv
// Purpose: protection, charger option and throttle trigger configuration registers
// Assumes: host protocol engine gives one-cycle rd/wr strobes with a command code
// Notes  : fields reach cfg_o one cycle after they are stored
//
// How it works
// - protect bit 4 picks comparator reference, 0 low level, 1 high level.
// - protect bit 3 at 1 disables the comparator; 0 keeps it on.
// - protect bit 2 inverts comparator output; 0 gives high while above reference.
// - protect bit 1 at 1 disables severe overcurrent protection.
// - protect bit 0 at 1 enables battery overvoltage protection.
// - option bit 15 at 1 suppresses config resistor reread.
// - option bit 14 at 1 stops input limit reload on adapter plug-in.
// - option bit 13 picks long autonomous termination time.
// - option bits 12:11 select host communication timeout, four lengths.
// - option bit 10 at 1 forces the battery switch gate off.
// - option bit 9 at 1 selects the lower power monitor gain.
// - option bit 8 at 1 selects the longer ideal diode exit timer.
// - option bit 7 at 1 hands charging current to the host.
// - option bit 6 at 1 halves adapter and charge loop feedback gain.
// - option bit 5 disables input limit loop; bit 4 only when battery absent.
// - option bit 3 at 1 reports reverse and discharge current.
// - writing 1 to option bit 2 restores all registers to defaults.
// - option bit 1 at 1 doubles the switching period.
// - option bit 0 shortens reverse start-up only with short reverse debounce.
// - throttle bits 7:4 enable alert from four separate sources.
// - throttle bits 3:2 select debounce for adapter loss or battery removal.
// - throttle bit 0 latches alert until 1 written to bit 1.
// - protect bit 13 at 1 selects the short reverse enable debounce.
`timescale 1ns/1ps
`default_nettype none
module cocr_regs #(
   parameter logic [14:0] DB2_CYC  = cocr_pkg::DB2_CYC,
   parameter logic [14:0] DB3_CYC  = cocr_pkg::DB3_CYC,
   parameter logic [34:0] TMO0_CYC = cocr_pkg::TMO0_CYC,
   parameter logic [34:0] TMO1_CYC = cocr_pkg::TMO1_CYC,
   parameter logic [34:0] TMO2_CYC = cocr_pkg::TMO2_CYC,
   parameter logic [34:0] TMO3_CYC = cocr_pkg::TMO3_CYC
) (
   input  wire logic                sys_clk_i,
   input  wire logic                srst_i,
   input  wire cocr_pkg::cocr_req_t req_i,
   input  wire logic                comparator_input_above_i,
   input  wire logic                battery_absent_i,
   input  wire logic                adapter_present_i,
   input  wire logic                reverse_output_current_over_i,
   output var  logic [15:0]         reg_rdata_o,
   output var  logic                reg_ack_o,
   output var  logic                comparator_output_o,
   output var  logic                throttle_alert_n_o,
   output var  logic                charger_timeout_o,
   output var  cocr_pkg::cocr_cfg_t cfg_o
);
   // ************************************************************
   // declarations
   // ************************************************************
   logic [15:0]         prot_r;
   logic [15:0]         prot_nxt;
   logic [15:0]         opt_r;
   logic [15:0]         opt_nxt;
   logic [15:0]         thr_r;
   logic [15:0]         thr_nxt;
   logic                clr_r;
   logic                clr_nxt;
   logic                soft_rst;
   logic [15:0]         rdata_r;
   logic [15:0]         rdata_nxt;
   logic                ack_r;
   logic                ack_nxt;
   cocr_pkg::cocr_cfg_t cfg_r;
   cocr_pkg::cocr_cfg_t cfg_nxt;
   logic                cmp_out_r;
   logic                cmp_out_nxt;
   logic                cmp_above_r;
   logic                cmp_en;
   logic                cmp_rise;
   logic                trip;
   logic                adp_lost_db;
   logic                bat_gone_db;
   logic                host_idle;
   logic [14:0]         db_cycles;
   logic [34:0]         tmo_cycles;

   // ************************************************************
   // register writes
   // ************************************************************
   always_comb begin
      prot_nxt = prot_r;
      opt_nxt  = opt_r;
      thr_nxt  = thr_r;
      clr_nxt  = 1'b0;
      soft_rst = 1'b0;
      if (req_i.wr) begin
         case (req_i.cmd)
            cocr_pkg::CMD_PROT: begin
               prot_nxt = req_i.wdata;
            end
            cocr_pkg::CMD_OPT: begin
               soft_rst = req_i.wdata[cocr_pkg::OPT_SOFT_RST];
               opt_nxt  = req_i.wdata & cocr_pkg::OPT_WMASK;
            end
            cocr_pkg::CMD_THR: begin
               thr_nxt = req_i.wdata & cocr_pkg::THR_WMASK;
               clr_nxt = req_i.wdata[cocr_pkg::THR_CLR];
            end
            default: begin
               clr_nxt = 1'b0;
            end
         endcase
      end
      if (soft_rst) begin
         prot_nxt = cocr_pkg::PROT_RST;
         opt_nxt  = cocr_pkg::OPT_RST;
         thr_nxt  = cocr_pkg::THR_RST;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         prot_r <= cocr_pkg::PROT_RST;
         opt_r  <= cocr_pkg::OPT_RST;
         thr_r  <= cocr_pkg::THR_RST;
         clr_r  <= 1'b0;
      end else begin
         prot_r <= prot_nxt;
         opt_r  <= opt_nxt;
         thr_r  <= thr_nxt;
         clr_r  <= clr_nxt;
      end
   end

   // ************************************************************
   // register reads
   // ************************************************************
   always_comb begin
      rdata_nxt = rdata_r;
      if (req_i.rd) begin
         case (req_i.cmd)
            cocr_pkg::CMD_PROT: rdata_nxt = prot_r;
            cocr_pkg::CMD_OPT:  rdata_nxt = opt_r;
            cocr_pkg::CMD_THR:  rdata_nxt = thr_r;
            default:            rdata_nxt = 16'h0000;
         endcase
      end
      ack_nxt = req_i.rd | req_i.wr;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rdata_r <= 16'h0000;
         ack_r   <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         ack_r   <= ack_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign reg_ack_o   = ack_r;

   // ************************************************************
   // decoded configuration and comparator
   // ************************************************************
   always_comb begin
      cmp_en                      = ~prot_r[cocr_pkg::PROT_CMP_DIS];
      cfg_nxt.cmp_ref_2v          = prot_r[cocr_pkg::PROT_CMP_REF];
      cfg_nxt.cmp_enable          = cmp_en;
      cfg_nxt.sev_oc_prot_en      = ~prot_r[cocr_pkg::PROT_SOC_DIS];
      cfg_nxt.bat_ov_prot_en      = prot_r[cocr_pkg::PROT_BOV_EN];
      cfg_nxt.rev_db_short        = prot_r[cocr_pkg::PROT_REV_DB];
      cfg_nxt.reread_disable      = opt_r[cocr_pkg::OPT_NO_REREAD];
      cfg_nxt.reload_disable      = opt_r[cocr_pkg::OPT_NO_RELOAD];
      cfg_nxt.term_200ms          = opt_r[cocr_pkg::OPT_TERM_LONG];
      cfg_nxt.timeout_sel         = opt_r[cocr_pkg::OPT_TMO_HI:cocr_pkg::OPT_TMO_LO];
      cfg_nxt.batt_gate_force_off = opt_r[cocr_pkg::OPT_SHIP];
      cfg_nxt.power_gain_low      = opt_r[cocr_pkg::OPT_PWR_GAIN];
      cfg_nxt.idm_exit_80ms       = opt_r[cocr_pkg::OPT_IDM_LONG];
      cfg_nxt.host_charge_ctrl    = opt_r[cocr_pkg::OPT_HOST_CHG];
      cfg_nxt.fb_gain_half        = opt_r[cocr_pkg::OPT_FB_HALF];
      cfg_nxt.icl_loop_en         = ~(opt_r[cocr_pkg::OPT_ICL_DIS]
                                      | (opt_r[cocr_pkg::OPT_ICL_BDIS]
                                         & battery_absent_i));
      cfg_nxt.monitor_reverse     = opt_r[cocr_pkg::OPT_MON_REV];
      cfg_nxt.period_double       = opt_r[cocr_pkg::OPT_PERIOD_X2];
      cfg_nxt.rev_start_1ms       = opt_r[cocr_pkg::OPT_REV_FAST]
                                    & prot_r[cocr_pkg::PROT_REV_DB];
      // output high while above reference unless inverted; low when disabled
      cmp_out_nxt = cmp_en
                    & (comparator_input_above_i ^ prot_r[cocr_pkg::PROT_CMP_INV]);
      cmp_rise    = cmp_en & comparator_input_above_i & ~cmp_above_r;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cfg_r       <= '0;
         cmp_out_r   <= 1'b0;
         cmp_above_r <= 1'b0;
      end else begin
         cfg_r       <= cfg_nxt;
         cmp_out_r   <= cmp_out_nxt;
         cmp_above_r <= comparator_input_above_i;
      end
   end

   assign cfg_o               = cfg_r;
   assign comparator_output_o = cmp_out_r;

   // ************************************************************
   // throttle alert sources
   // ************************************************************
   always_comb begin
      case (thr_r[cocr_pkg::THR_DB_HI:cocr_pkg::THR_DB_LO])
         2'b00:   db_cycles = cocr_pkg::DB0_CYC;
         2'b01:   db_cycles = cocr_pkg::DB1_CYC;
         2'b10:   db_cycles = DB2_CYC;
         2'b11:   db_cycles = DB3_CYC;
         default: db_cycles = cocr_pkg::DB0_CYC;
      endcase
      trip = (thr_r[cocr_pkg::THR_EN_REVOC]  & reverse_output_current_over_i)
           | (thr_r[cocr_pkg::THR_EN_BATABS] & bat_gone_db)
           | (thr_r[cocr_pkg::THR_EN_ADP]    & adp_lost_db)
           | (thr_r[cocr_pkg::THR_EN_CMP]    & cmp_rise);
   end

   cocr_debounce #(
      .W (cocr_pkg::DB_W)
   ) u_adp_lost (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .level_i   (~adapter_present_i),
      .cycles_i  (db_cycles),
      .stable_o  (adp_lost_db)
   );

   cocr_debounce #(
      .W (cocr_pkg::DB_W)
   ) u_bat_gone (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .level_i   (battery_absent_i),
      .cycles_i  (db_cycles),
      .stable_o  (bat_gone_db)
   );

   cocr_alert u_alert (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .trip_i    (trip),
      .latch_i   (thr_r[cocr_pkg::THR_LATCH]),
      .clear_i   (clr_r),
      .alert_n_o (throttle_alert_n_o)
   );

   // ************************************************************
   // host communication timeout
   // ************************************************************
   always_comb begin
      host_idle = ~(req_i.rd | req_i.wr);
      case (opt_r[cocr_pkg::OPT_TMO_HI:cocr_pkg::OPT_TMO_LO])
         2'b00:   tmo_cycles = TMO0_CYC;
         2'b01:   tmo_cycles = TMO1_CYC;
         2'b10:   tmo_cycles = TMO2_CYC;
         2'b11:   tmo_cycles = TMO3_CYC;
         default: tmo_cycles = TMO0_CYC;
      endcase
   end

   cocr_debounce #(
      .W (cocr_pkg::TMO_W)
   ) u_timeout (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .level_i   (host_idle),
      .cycles_i  (tmo_cycles),
      .stable_o  (charger_timeout_o)
   );

   // ************************************************************
   // checks
   // ************************************************************
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   sequence s_soft_write;
      req_i.wr && req_i.cmd == cocr_pkg::CMD_OPT && req_i.wdata[cocr_pkg::OPT_SOFT_RST];
   endsequence
   sequence s_clear_write;
      req_i.wr && req_i.cmd == cocr_pkg::CMD_THR && req_i.wdata[cocr_pkg::THR_CLR];
   endsequence
   sequence s_prot_write_read;
      req_i.wr && req_i.cmd == cocr_pkg::CMD_PROT ##1 !req_i.wr
      ##1 req_i.rd && req_i.cmd == cocr_pkg::CMD_PROT && !req_i.wr;
   endsequence

   a_soft_reset_all: assert property (s_soft_write |=>
      prot_r == cocr_pkg::PROT_RST && opt_r == cocr_pkg::OPT_RST
      && thr_r == cocr_pkg::THR_RST)
      else $error("soft reset did not restore defaults");
   a_clear_one_shot: assert property (s_clear_write |=>
      clr_r && !thr_r[cocr_pkg::THR_CLR] ##1 (!clr_r || ($past(req_i.wr)
      && $past(req_i.cmd) == cocr_pkg::CMD_THR && $past(req_i.wdata[cocr_pkg::THR_CLR]))))
      else $error("alert clear not a single pulse");
   a_unused_zero: assert property (thr_r[15:8] == 8'h00
      && !opt_r[cocr_pkg::OPT_SOFT_RST])
      else $error("unused or command bit reads nonzero");
   a_cmp_disabled: assert property (prot_r[cocr_pkg::PROT_CMP_DIS]
      |=> !comparator_output_o)
      else $error("disabled comparator drove output");
   a_cmp_polarity: assert property (cmp_en && comparator_input_above_i
      && !prot_r[cocr_pkg::PROT_CMP_INV] |=> comparator_output_o)
      else $error("comparator polarity wrong");
   a_ship_mode: assert property (opt_r[cocr_pkg::OPT_SHIP]
      |=> cfg_o.batt_gate_force_off)
      else $error("ship mode did not force gate off");
   a_icl_gated: assert property (opt_r[cocr_pkg::OPT_ICL_BDIS] && battery_absent_i
      |=> !cfg_o.icl_loop_en)
      else $error("input limit loop not disabled");
   a_rev_fast: assert property (!prot_r[cocr_pkg::PROT_REV_DB]
      |=> !cfg_o.rev_start_1ms)
      else $error("fast reverse start without short debounce");
   a_access_restart: assert property (req_i.rd || req_i.wr |=> !charger_timeout_o)
      else $error("timeout stood after host access");
   a_read_back: assert property (s_prot_write_read |=>
      reg_rdata_o == $past(req_i.wdata, 3) && reg_ack_o)
      else $error("protect register read back wrong");
endmodule // cocr_regs
`default_nettype wire

//--- test/cocr_host_model.sv
// Purpose: host side model, issues one register access at a time
// Assumes: answer one cycle after the request edge
// Notes  : write data idles at the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module cocr_host_model (
   input  wire logic                sys_clk_i,
   input  wire logic [15:0]         rdata_i,
   input  wire logic                ack_i,
   output var  cocr_pkg::cocr_req_t req_o
);
   initial req_o = '0;
   // caller's data goes out unmasked; tb writes 16'hFF13 with unused bits set
   task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge sys_clk_i);
      req_o <= '{cmd: c, wr: w, rd: !w, wdata: d};
      @(posedge sys_clk_i);
      req_o <= '{cmd: c, wr: 1'b0, rd: 1'b0, wdata: ~d};
      #1;
      q = ack_i ? rdata_i : 16'hXXXX;
   endtask
endmodule // cocr_host_model
`default_nettype wire

//--- test/tb.sv
// Purpose: register bank regression
// Assumes: shortened debounce and timeout counts
// Notes  : host accesses go through the host model
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                sys_clk_i, srst_i, above, bat_abs, adp, rev_oc, ack, cmp_out, alert_n, tmo;
   logic [15:0]         rdata, q;
   cocr_pkg::cocr_req_t req;
   cocr_pkg::cocr_cfg_t cfg;
   int                  fails, checks_done;
   cocr_host_model u_host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .ack_i(ack), .req_o(req));
   cocr_regs #(.DB2_CYC(15'h14), .TMO0_CYC(35'hC8), .TMO1_CYC(35'h96),
      .TMO2_CYC(35'h64), .TMO3_CYC(35'h32)) DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .req_i(req), .comparator_input_above_i(above), .battery_absent_i(bat_abs),
      .adapter_present_i(adp), .reverse_output_current_over_i(rev_oc), .reg_rdata_o(rdata),
      .reg_ack_o(ack), .comparator_output_o(cmp_out), .throttle_alert_n_o(alert_n),
      .charger_timeout_o(tmo), .cfg_o(cfg));
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      u_host.xfer(c, 1'b1, d, q);
      chk("ack", 16'h0001, {15'h0000, ack});
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      u_host.xfer(c, 1'b0, 16'h0000, q);
      chk("rdata", e, q);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic summarize;
      if (fails == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ********************
   // tests
   // ********************
   initial begin
      fails = 0;
      checks_done = 0;
      {srst_i, above, bat_abs, adp, rev_oc} = 5'b10000;
      repeat (8) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      rd(cocr_pkg::CMD_PROT, 16'h0000);
      rd(cocr_pkg::CMD_OPT, 16'h0000);
      rd(8'h3E, 16'h0000);
      wr(cocr_pkg::CMD_PROT, 16'h0017);
      rd(cocr_pkg::CMD_PROT, 16'h0017);
      chk("prot", 16'h000D, {12'h000, cfg.cmp_ref_2v, cfg.cmp_enable, cfg.sev_oc_prot_en,
          cfg.bat_ov_prot_en});
      chk("cmp_out", 16'h0001, {15'h0000, cmp_out});
      wr(cocr_pkg::CMD_PROT, 16'h0000);
      wr(cocr_pkg::CMD_OPT, 16'hFFFB);
      rd(cocr_pkg::CMD_OPT, 16'hFFFB);
      chk("opt", 16'h007A, {9'h000, cfg.timeout_sel, cfg.batt_gate_force_off,
          cfg.host_charge_ctrl, cfg.icl_loop_en, cfg.period_double, cfg.rev_start_1ms});
      chk("opt_misc", 16'h007F, {9'h000, cfg.reread_disable, cfg.reload_disable, cfg.term_200ms,
          cfg.power_gain_low, cfg.idm_exit_80ms, cfg.fb_gain_half, cfg.monitor_reverse});
      wr(cocr_pkg::CMD_PROT, 16'h200C);
      cyc(1);
      chk("cmp_off", 16'h0000, {15'h0000, cmp_out});
      chk("rev", 16'h0003, {14'h0000, cfg.rev_db_short, cfg.rev_start_1ms});
      cyc(40);
      chk("tmo_early", 16'h0000, {15'h0000, tmo});
      cyc(20);
      chk("tmo_late", 16'h0001, {15'h0000, tmo});
      wr(cocr_pkg::CMD_THR, 16'h0011);
      wr(cocr_pkg::CMD_OPT, 16'h0004);
      rd(cocr_pkg::CMD_OPT, 16'h0000);
      rd(cocr_pkg::CMD_THR, 16'h0000);
      wr(cocr_pkg::CMD_THR, 16'hFF13);
      rd(cocr_pkg::CMD_THR, 16'h0011);
      @(posedge sys_clk_i) above <= 1'b1;
      cyc(6);
      chk("alert_cmp", 16'h0000, {15'h0000, alert_n});
      @(posedge sys_clk_i) above <= 1'b0;
      cyc(6);
      chk("alert_held", 16'h0000, {15'h0000, alert_n});
      wr(cocr_pkg::CMD_THR, 16'h0013);
      cyc(3);
      chk("alert_clr", 16'h0001, {15'h0000, alert_n});
      wr(cocr_pkg::CMD_THR, 16'h0048);
      @(posedge sys_clk_i) bat_abs <= 1'b1;
      cyc(15);
      chk("db_early", 16'h0001, {15'h0000, alert_n});
      cyc(10);
      chk("db_trip", 16'h0000, {15'h0000, alert_n});
      @(posedge sys_clk_i) bat_abs <= 1'b0;
      cyc(4);
      chk("auto_clr", 16'h0001, {15'h0000, alert_n});
      summarize();
   end
   initial begin
      cyc(2000);
      fails++;
      summarize();
   end
endmodule // tb
`default_nettype wire
